// ---- common/mlc_map.vh ----
// register indices, field positions, reset values and constants of the microphone level control block
`ifndef MLC_MAP_VH
`define MLC_MAP_VH
// register indices (byte address is four times the index)
`define MLC_IDX_MANUAL 12'hB12
`define MLC_IDX_ENVSPD 12'hB85
`define MLC_IDX_RATE 12'hB8A
`define MLC_IDX_ENABLE 12'hB8B
`define MLC_IDX_AUX 12'hB8C
`define MLC_IDX_STATUS 12'hB8D
`define MLC_IDX_ENVEL 12'hB8E
`define MLC_IDX_TARGET 12'hBA0
`define MLC_IDX_SELHOLD 12'hBA1
`define MLC_IDX_RATES 12'hBA2
`define MLC_IDX_GATE 12'hBA3
`define MLC_IDX_FLOOR 12'hBA4
// reset values
`define MLC_RST_MANUAL 8'h20
`define MLC_RST_ENVSPD 8'h40
`define MLC_RST_RATE 8'h00
`define MLC_RST_ENABLE 8'h00
`define MLC_RST_AUX 8'h00
`define MLC_RST_TARGET 8'hF8
`define MLC_RST_SELHOLD 8'h00
`define MLC_RST_RATES 8'h22
`define MLC_RST_GATE 8'h00
`define MLC_RST_FLOOR 8'h00
// field positions
`define MLC_F_CHAIN_EN 1
`define MLC_F_CLK_EN 0
`define MLC_F_RATE_MSB 5
`define MLC_F_RATE_LSB 1
`define MLC_F_CMODE_MSB 7
`define MLC_F_CMODE_LSB 6
`define MLC_F_HALVE 0
`define MLC_F_ENVSPD_MSB 7
`define MLC_F_ENVSPD_LSB 4
`define MLC_F_SEL_MSB 6
`define MLC_F_SEL_LSB 5
`define MLC_F_HOLD_MSB 3
`define MLC_F_HOLD_LSB 0
`define MLC_F_GATE_EN 0
`define MLC_F_GACT_MSB 2
`define MLC_F_GACT_LSB 1
`define MLC_F_GTHR_MSB 7
`define MLC_F_GTHR_LSB 3
// processing constants
`define MLC_GAIN_UNITY 4'h4
`define MLC_GAIN_OFFSET 5'h04
`define MLC_SHIFT_NONE 4'h8
`define MLC_PHASE_STEP 11'h004
`define MLC_CIC_MAXCNT 8'hFF
`define MLC_FIFO_WIDTH 32
`define MLC_FIFO_DEPTH 32
`define MLC_FIFO_AW 5
`endif

// ---- hdl/mlc_fifo.v ----
// sample fifo with parameterised width and depth and a registered read port
`timescale 1ns/1ps
module mlc_fifo #(
  parameter W = 32,
  parameter D = 32,
  parameter AW = 5
) (
  input wire mclk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wptr_q;
  reg [AW-1:0] rptr_q;
  reg [AW:0] count_q;
  wire push;
  wire load;
  assign in_ready = (count_q < D[AW:0]);
  assign push = in_valid & in_ready;
  // refill the output register when it is empty or being drained
  assign load = (count_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  ////////////////////////////////////////////////////////////////////////////
  // storage has no reset, only the pointers, fill level and output stage do
  always @(posedge mclk)
  begin
    if (push)
      mem[wptr_q] <= in_data;
  end

  // pointers, fill level and output stage
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wptr_q <= {AW{1'b0}};
      rptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {W{1'b0}};
    end
    else
    begin
      if (push)
        wptr_q <= wptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (load)
      begin
        rptr_q <= rptr_q + {{(AW-1){1'b0}}, 1'b1};
        out_data <= mem[rptr_q];
        out_valid <= 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
      count_q <= count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end
  end
endmodule // mlc_fifo

// ---- hdl/mlc_top.v ----
// microphone path: decimating filter chain, manual gain and shift, automatic level control, output fifo
`timescale 1ns/1ps
`include "mlc_map.vh"
module mlc_top (
  input wire mclk,
  input wire sys_rst,
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire codec_tick,
  input wire adc_valid,
  input wire [15:0] adc_data,
  output wire aud_valid,
  input wire aud_ready,
  output wire [31:0] aud_data
);
  localparam ST_ATTACK = 3'b001;
  localparam ST_HOLD = 3'b010;
  localparam ST_DECAY = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function signed [15:0] mlc_sat16;
    input signed [23:0] v;
    begin
      if (v > 24'sh007FFF)
        mlc_sat16 = 16'sh7FFF;
      else if (v < -24'sh008000)
        mlc_sat16 = 16'sh8000;
      else
        mlc_sat16 = v[15:0];
    end
  endfunction

  // three tap halfband kernel, weights one two one over four
  function signed [15:0] mlc_hb;
    input signed [15:0] a;
    input signed [15:0] b;
    input signed [15:0] c;
    reg signed [17:0] s;
    begin
      s = {{2{a[15]}}, a} + {b[15], b, 1'b0} + {{2{c[15]}}, c};
      mlc_hb = s[17:2];
    end
  endfunction

  // step period mask, two to the rate minus one
  function [15:0] mlc_mask;
    input [3:0] r;
    begin
      mlc_mask = (16'h0001 << r) - 16'h0001;
    end
  endfunction

  // keep gain inside ceiling, floor taking precedence
  function [3:0] mlc_clamp;
    input [3:0] g;
    input [3:0] ceil;
    input [2:0] flr;
    begin
      mlc_clamp = (g > ceil) ? ceil : g;
      if (mlc_clamp < {1'b0, flr})
        mlc_clamp = {1'b0, flr};
    end
  endfunction

  // master clocks per output sample for each rate code
  function [10:0] mlc_ratio;
    input [4:0] code;
    begin
      case (code)
        5'h06, 5'h04: mlc_ratio = 11'd1500;
        5'h17, 5'h15: mlc_ratio = 11'd1496;
        5'h19: mlc_ratio = 11'd1088;
        5'h08: mlc_ratio = 11'd1000;
        5'h0A: mlc_ratio = 11'd750;
        5'h1B: mlc_ratio = 11'd544;
        5'h1C: mlc_ratio = 11'd500;
        5'h0C: mlc_ratio = 11'd375;
        5'h13, 5'h11: mlc_ratio = 11'd272;
        5'h1F: mlc_ratio = 11'd136;
        5'h0E: mlc_ratio = 11'd125;
        default: mlc_ratio = 11'd250;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus: one wait cycle, then the access completes
  reg [7:0] manual_q, envspd_q, rate_q, enable_q, aux_q, target_q, selhold_q, rates_q, gate_q, floor_q;
  reg ovf_q;
  reg gated_q;
  reg [3:0] gain_q;
  reg signed [17:0] env_q;
  reg [7:0] rd_mux;
  wire bus_req = avs_read | avs_write;
  wire wr_fire = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire ovf_clr = wr_fire & (avs_address == `MLC_IDX_STATUS) & avs_writedata[0];

  always @*
  begin
    case (avs_address)
      `MLC_IDX_MANUAL: rd_mux = manual_q;
      `MLC_IDX_ENVSPD: rd_mux = envspd_q;
      `MLC_IDX_RATE: rd_mux = rate_q;
      `MLC_IDX_ENABLE: rd_mux = enable_q;
      `MLC_IDX_AUX: rd_mux = aux_q;
      `MLC_IDX_STATUS: rd_mux = {gain_q, 2'b00, gated_q, ovf_q};
      `MLC_IDX_ENVEL: rd_mux = env_q[15:8];
      `MLC_IDX_TARGET: rd_mux = target_q;
      `MLC_IDX_SELHOLD: rd_mux = selhold_q;
      `MLC_IDX_RATES: rd_mux = rates_q;
      `MLC_IDX_GATE: rd_mux = gate_q;
      `MLC_IDX_FLOOR: rd_mux = floor_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // handshake, read capture and configuration writes
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      manual_q <= `MLC_RST_MANUAL;
      envspd_q <= `MLC_RST_ENVSPD;
      rate_q <= `MLC_RST_RATE;
      enable_q <= `MLC_RST_ENABLE;
      aux_q <= `MLC_RST_AUX;
      target_q <= `MLC_RST_TARGET;
      selhold_q <= `MLC_RST_SELHOLD;
      rates_q <= `MLC_RST_RATES;
      gate_q <= `MLC_RST_GATE;
      floor_q <= `MLC_RST_FLOOR;
    end
    else
    begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
      if (avs_read & avs_waitrequest)
        avs_readdata <= {24'h000000, rd_mux};
      if (wr_fire)
      begin
        case (avs_address)
          `MLC_IDX_MANUAL: manual_q <= avs_writedata[7:0];
          `MLC_IDX_ENVSPD: envspd_q <= avs_writedata[7:0];
          `MLC_IDX_RATE: rate_q <= avs_writedata[7:0];
          `MLC_IDX_ENABLE: enable_q <= avs_writedata[7:0];
          `MLC_IDX_AUX: aux_q <= avs_writedata[7:0];
          `MLC_IDX_TARGET: target_q <= avs_writedata[7:0];
          `MLC_IDX_SELHOLD: selhold_q <= avs_writedata[7:0];
          `MLC_IDX_RATES: rates_q <= avs_writedata[7:0];
          `MLC_IDX_GATE: gate_q <= avs_writedata[7:0];
          `MLC_IDX_FLOOR: floor_q <= avs_writedata[7:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output rate: fractional phase, four comb outputs per final sample
  // chain and clock gating
  wire chain_on = enable_q[`MLC_F_CHAIN_EN] & rate_q[`MLC_F_CLK_EN];
  wire [10:0] ratio = mlc_ratio(rate_q[`MLC_F_RATE_MSB:`MLC_F_RATE_LSB]);
  reg half_q;
  reg [10:0] phase_q;
  wire [10:0] phase_nx = phase_q + `MLC_PHASE_STEP;
  wire [10:0] phase_rem = phase_nx - ratio;
  // with halving set only every second master tick counts
  wire eff_tick = codec_tick & (~aux_q[`MLC_F_HALVE] | half_q) & chain_on;
  wire cic_emit = eff_tick & (phase_nx >= ratio);

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      half_q <= 1'b0;
      phase_q <= 11'h000;
    end
    else
    begin
      if (codec_tick)
        half_q <= ~half_q;
      if (eff_tick)
        phase_q <= ~cic_emit ? phase_nx : ((phase_rem >= ratio) ? 11'h000 : phase_rem);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // filter chain, each stage with a one-cycle valid strobe
  reg signed [23:0] acc_q;
  reg [7:0] cnt_q;
  reg cic_v_q, hb1_v_q, hb2_v_q, dr_v_q, hp_v_q, man_v_q;
  reg hb1_ph_q, hb2_ph_q;
  reg signed [15:0] cic_y_q, hb1_a_q, hb1_b_q, hb1_y_q, hb2_a_q, hb2_b_q, hb2_y_q;
  reg signed [15:0] dr_p_q, dr_y_q, hp_y_q, man_y_q;
  reg signed [23:0] dc_q;
  wire signed [23:0] adc_ext = {{8{adc_data[15]}}, adc_data};
  wire take = adc_valid & chain_on & (cnt_q != `MLC_CIC_MAXCNT);
  // power-of-two normalisation of the comb sum, cheaper than a divider
  wire [2:0] norm = cnt_q[7] ? 3'd7 : cnt_q[6] ? 3'd6 : cnt_q[5] ? 3'd5 : cnt_q[4] ? 3'd4 :
                    cnt_q[3] ? 3'd3 : cnt_q[2] ? 3'd2 : cnt_q[1] ? 3'd1 : 3'd0;
  // every operand signed, or the shift of a falling step would fill with zeros
  wire signed [23:0] dr_sum = $signed({{8{hb2_y_q[15]}}, hb2_y_q}) + ($signed(
                               {{8{hb2_y_q[15]}}, hb2_y_q} - {{8{dr_p_q[15]}}, dr_p_q}) >>> 3);
  wire signed [23:0] hp_diff = {{8{dr_y_q[15]}}, dr_y_q} - {{8{dc_q[23]}}, dc_q[23:8]};
  wire signed [23:0] hp_ext = {{8{hp_y_q[15]}}, hp_y_q};
  wire signed [23:0] man_sc = hp_ext + (manual_q[0] ? (hp_ext >>> 2) : 24'sh000000)
                                     + (manual_q[1] ? (hp_ext >>> 1) : 24'sh000000);
  wire [3:0] shf = manual_q[5:2];
  wire signed [23:0] man_sh = (shf >= `MLC_SHIFT_NONE) ? (man_sc <<< (shf - `MLC_SHIFT_NONE))
                                                       : (man_sc >>> (`MLC_SHIFT_NONE - shf));

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc_q <= 24'sh000000;
      cnt_q <= 8'h00;
      {cic_v_q, hb1_v_q, hb2_v_q, dr_v_q, hp_v_q, man_v_q} <= 6'h00;
      {hb1_ph_q, hb2_ph_q} <= 2'b00;
      {cic_y_q, hb1_a_q, hb1_b_q, hb1_y_q} <= 64'h0;
      {hb2_a_q, hb2_b_q, hb2_y_q, dr_p_q} <= 64'h0;
      {dr_y_q, hp_y_q, man_y_q} <= 48'h0;
      dc_q <= 24'sh000000;
    end
    else
    begin
      cic_v_q <= cic_emit;
      if (cic_emit)
      begin
        cic_y_q <= mlc_sat16(acc_q >>> norm);
        acc_q <= take ? adc_ext : 24'sh000000;
        cnt_q <= take ? 8'h01 : 8'h00;
      end
      else if (take)
      begin
        acc_q <= acc_q + adc_ext;
        cnt_q <= cnt_q + 8'h01;
      end
      // first halfband keeps every second output
      hb1_v_q <= cic_v_q & hb1_ph_q;
      if (cic_v_q)
      begin
        hb1_ph_q <= ~hb1_ph_q;
        hb1_b_q <= hb1_a_q;
        hb1_a_q <= cic_y_q;
        hb1_y_q <= mlc_hb(cic_y_q, hb1_a_q, hb1_b_q);
      end
      hb2_v_q <= hb1_v_q & hb2_ph_q;
      if (hb1_v_q)
      begin
        hb2_ph_q <= ~hb2_ph_q;
        hb2_b_q <= hb2_a_q;
        hb2_a_q <= hb1_y_q;
        hb2_y_q <= mlc_hb(hb1_y_q, hb2_a_q, hb2_b_q);
      end
      // droop lift, then a first-order dc blocker
      dr_v_q <= hb2_v_q;
      if (hb2_v_q)
      begin
        dr_p_q <= hb2_y_q;
        dr_y_q <= mlc_sat16(dr_sum);
      end
      hp_v_q <= dr_v_q;
      if (dr_v_q)
      begin
        dc_q <= dc_q + $signed({{8{dr_y_q[15]}}, dr_y_q}) - (dc_q >>> 8);
        hp_y_q <= mlc_sat16(hp_diff);
      end
      man_v_q <= hp_v_q;
      // unity at gain code zero with shift code eight, saturate after shift
      if (hp_v_q)
        man_y_q <= mlc_sat16(man_sh);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level control: envelope, gain state machine, gate
  reg [2:0] st_q;
  reg [15:0] step_q;
  reg [7:0] hold_q;
  reg [3:0] att_q;
  reg alc_v_q;
  reg [31:0] pend_q;
  reg pend_v_q;
  wire [15:0] mag = man_y_q[15] ? ((man_y_q == 16'sh8000) ? 16'h7FFF : (16'h0000 - man_y_q)) : man_y_q;
  wire signed [17:0] env_dif = {2'b00, mag} - env_q;
  wire over = env_q[15:12] > target_q[3:0];
  wire below = gate_q[`MLC_F_GATE_EN] & (env_q[15:11] < gate_q[`MLC_F_GTHR_MSB:`MLC_F_GTHR_LSB]);
  wire [1:0] gact = gate_q[`MLC_F_GACT_MSB:`MLC_F_GACT_LSB];
  wire [3:0] ceil = target_q[7:4];
  wire [2:0] flr = floor_q[2:0];
  wire [15:0] atk_m = mlc_mask(rates_q[3:0]);
  wire [15:0] dcy_m = mlc_mask(rates_q[7:4]);
  wire signed [5:0] mult = {1'b0, {1'b0, gain_q} + `MLC_GAIN_OFFSET};
  wire signed [21:0] prod = man_y_q * mult;
  wire signed [15:0] gained = mlc_sat16({{5{prod[21]}}, prod[21:3]});
  // gated result: hard or soft mute
  wire signed [15:0] alc_y = (below & (gact == 2'b01)) ? 16'sh0000 : (gained >>> att_q);
  wire [1:0] sel = selhold_q[`MLC_F_SEL_MSB:`MLC_F_SEL_LSB];
  wire fifo_ready;
  wire push = pend_v_q & fifo_ready;

  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      env_q <= 18'sh00000;
      st_q <= ST_ATTACK;
      step_q <= 16'h0000;
      hold_q <= 8'h00;
      gain_q <= `MLC_GAIN_UNITY;
      att_q <= 4'h0;
      gated_q <= 1'b0;
    end
    else if (man_v_q)
    begin
      env_q <= env_q + (env_dif >>> envspd_q[`MLC_F_ENVSPD_MSB:`MLC_F_ENVSPD_LSB]);
      gated_q <= below;
      att_q <= (below & (gact == 2'b10)) ? ((att_q == 4'hF) ? att_q : att_q + 4'h1)
                                         : ((att_q == 4'h0) ? att_q : att_q - 4'h1);
      if (!(below & (gact == 2'b00)))
      begin
        gain_q <= mlc_clamp(gain_q, ceil, flr);
        case (st_q)
          ST_ATTACK:
          begin
            if (!over)
            begin
              st_q <= ST_HOLD;
              hold_q <= {selhold_q[`MLC_F_HOLD_MSB:`MLC_F_HOLD_LSB], 4'h0};
              step_q <= 16'h0000;
            end
            else if (step_q >= atk_m)
            begin
              step_q <= 16'h0000;
              gain_q <= mlc_clamp((gain_q == 4'h0) ? 4'h0 : gain_q - 4'h1, ceil, flr);
            end
            else
              step_q <= step_q + 16'h0001;
          end
          ST_HOLD:
          begin
            if (over)
              st_q <= ST_ATTACK;
            else if (hold_q == 8'h00)
              st_q <= ST_DECAY;
            else
              hold_q <= hold_q - 8'h01;
          end
          ST_DECAY:
          begin
            if (over)
            begin
              st_q <= ST_ATTACK;
              step_q <= 16'h0000;
            end
            else if (step_q >= dcy_m)
            begin
              step_q <= 16'h0000;
              gain_q <= mlc_clamp((gain_q == 4'hF) ? 4'hF : gain_q + 4'h1, ceil, flr);
            end
            else
              step_q <= step_q + 16'h0001;
          end
          default: st_q <= ST_ATTACK;
        endcase
      end
    end
  end

  // output word, left high half; a sample arriving while one waits is counted as overflow
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      alc_v_q <= 1'b0;
      pend_q <= 32'h00000000;
      pend_v_q <= 1'b0;
      ovf_q <= 1'b0;
    end
    else
    begin
      alc_v_q <= man_v_q;
      // set wins over a software clear
      if (alc_v_q & pend_v_q & ~push)
        ovf_q <= 1'b1;
      else if (ovf_clr)
        ovf_q <= 1'b0;
      if (alc_v_q & ~(pend_v_q & ~push))
      begin
        pend_q <= {sel[1] ? alc_y : man_y_q, sel[0] ? alc_y : man_y_q};
        pend_v_q <= 1'b1;
      end
      else if (push)
        pend_v_q <= 1'b0;
    end
  end

  mlc_fifo #(
    .W(`MLC_FIFO_WIDTH),
    .D(`MLC_FIFO_DEPTH),
    .AW(`MLC_FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(pend_v_q),
    .in_ready(fifo_ready),
    .in_data(pend_q),
    .out_valid(aud_valid),
    .out_ready(aud_ready),
    .out_data(aud_data)
  );
endmodule // mlc_top

// ---- bench/mlc_monitor.sv ----
// port checker for the microphone level control block
`timescale 1ns/1ps
module mlc_monitor (
  input wire mclk,
  input wire sys_rst,
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire codec_tick,
  input wire adc_valid,
  input wire [15:0] adc_data,
  input wire aud_valid,
  input wire aud_ready,
  input wire [31:0] aud_data
);
  logic en_seen_q;
  logic sel_off_q;
  logic mapped;
  assign mapped = avs_address inside {12'hB12, 12'hB85, 12'hB8A, 12'hB8B, 12'hB8C, 12'hB8D, 12'hB8E, 12'hBA0,
    12'hBA1, 12'hBA2, 12'hBA3, 12'hBA4};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // follow chain enable and channel select from completed writes only
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      en_seen_q <= 1'b0;
      sel_off_q <= 1'b1;
    end
    else if (avs_write && !avs_waitrequest && avs_byteenable[0])
    begin
      if (avs_address == 12'hB8B && avs_writedata[1])
        en_seen_q <= 1'b1;
      if (avs_address == 12'hBA1)
        sel_off_q <= (avs_writedata[6:5] == 2'b00);
    end
  end
  ////////////////////////////////////////////////////////////
  // a request is taken, answered one cycle later, then wait rises again
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus answer not after one wait cycle");
  chk_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("wait dropped without request");
  chk_rdata_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  chk_rdata_stand: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without read");
  chk_unmapped_zero: assert property (avs_read && avs_waitrequest && !mapped |=> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_aud_hold: assert property (aud_valid && !aud_ready |=> aud_valid && $stable(aud_data))
    else $error("output sample not held");
  chk_off_silent: assert property (!en_seen_q |-> !aud_valid)
    else $error("output while chain never enabled");
  chk_lr_copy: assert property (aud_valid && sel_off_q |-> aud_data[31:16] == aud_data[15:0])
    else $error("halves differ with level control off");
endmodule // mlc_monitor
bind mlc_top mlc_monitor i_mon (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .codec_tick(codec_tick),
  .adc_valid(adc_valid), .adc_data(adc_data), .aud_valid(aud_valid), .aud_ready(aud_ready), .aud_data(aud_data));

// ---- bench/mlc_adc_model.sv ----
// microphone converter side: codec ticks and sample pulses
`timescale 1ns/1ps
module mlc_adc_model #(
  parameter GAP = 4
) (
  input wire mclk,
  input wire sys_rst,
  input wire run,
  input wire [15:0] sample,
  output logic codec_tick,
  output logic adc_valid,
  output logic [15:0] adc_data
);
  int cnt;
  ////////////////////////////////////////////////////////////
  // feeds the chain
  // one sample every GAP cycles; between samples the bus inverts every cycle so stale data is never trusted
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      codec_tick <= 1'b0;
      adc_valid <= 1'b0;
      adc_data <= 16'h0000;
      cnt <= 0;
    end
    else
    begin
      codec_tick <= run;
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      adc_valid <= run && cnt == 0;
      adc_data <= (run && cnt == 0) ? sample : ~adc_data;
    end
  end
endmodule // mlc_adc_model

// ---- bench/mlc_top_tb.sv ----
// self-checking bench: registers, output rate, fifo, level control, noise gate
`timescale 1ns/1ps
`include "mlc_map.vh"
module mlc_top_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic codec_tick;
  logic adc_valid;
  logic [15:0] adc_data;
  logic [15:0] sample = 16'h0000;
  logic aud_valid;
  logic aud_ready = 1'b1;
  logic run = 1'b0;
  logic [31:0] aud_data;
  logic [31:0] rd;
  logic [31:0] rng = 32'd60;
  bit [7:0] mdl [bit [11:0]];
  bit [7:0] rst_m [bit [11:0]];
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int sel_on = 0;
  int t0;
  int t1;
  int n;
  int k;
  int codes [4] = '{5'b01110, 5'b01000, 5'b01100, 5'b01110};
  int ratio [4] = '{125, 1000, 375, 250};
  ////////////////////////////////////////////////////////////
  mlc_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .codec_tick(codec_tick),
    .adc_valid(adc_valid), .adc_data(adc_data), .aud_valid(aud_valid), .aud_ready(aud_ready), .aud_data(aud_data));
  mlc_adc_model i_adc (.mclk(mclk), .sys_rst(sys_rst), .run(run), .sample(sample), .codec_tick(codec_tick),
    .adc_valid(adc_valid), .adc_data(adc_data));
  ////////////////////////////////////////////////////////////
  // clock and a large square wave with random low bits, slow enough to pass the highpass
  always #50 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    rng <= xs(rng);
    sample <= (cyc[9] ? 16'h6000 : 16'hA000) ^ {12'h000, rng[3:0]};
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  ////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic hang(input string what);
    n_fail++;
    $display("MISMATCH t=%0t timeout %s", $time, what);
    print_verdict();
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
    int i;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    for (i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20)
      hang("bus");
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be);
    if (be[0] && mdl.exists(a))
      mdl[a] = d;
  endtask
  task automatic rdchk(input logic [11:0] a);
    bus(1'b0, a, 8'h00, 4'h1);
    chk(rd, mdl.exists(a) ? {24'h000000, mdl[a]} : 32'h00000000, "register read");
  endtask
  // next accepted output; halves must match while level control is off
  task automatic get_out(output int t);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge mclk);
      if (aud_valid === 1'b1 && aud_ready === 1'b1)
        break;
    end
    t = cyc;
    if (i == 3000)
      hang("output");
    else if (sel_on == 0)
      chk({16'h0000, aud_data[31:16]}, {16'h0000, aud_data[15:0]}, "channel copy");
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    mdl[`MLC_IDX_MANUAL] = `MLC_RST_MANUAL;
    mdl[`MLC_IDX_ENVSPD] = `MLC_RST_ENVSPD;
    mdl[`MLC_IDX_RATE] = `MLC_RST_RATE;
    mdl[`MLC_IDX_ENABLE] = `MLC_RST_ENABLE;
    mdl[`MLC_IDX_TARGET] = `MLC_RST_TARGET;
    mdl[`MLC_IDX_SELHOLD] = `MLC_RST_SELHOLD;
    mdl[`MLC_IDX_RATES] = `MLC_RST_RATES;
    mdl[`MLC_IDX_GATE] = `MLC_RST_GATE;
    mdl[`MLC_IDX_FLOOR] = `MLC_RST_FLOOR;
    rst_m = mdl;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    // reset values, random readback, masked write, unmapped place
    foreach (mdl[a]) rdchk(a);
    foreach (mdl[a])
    begin
      wr(a, rng[7:0], 4'h1);
      rdchk(a);
    end
    wr(12'hB12, 8'h55, 4'h0);
    rdchk(12'hB12);
    wr(12'h123, 8'hAA, 4'hF);
    rdchk(12'h123);
    foreach (rst_m[a]) wr(a, rst_m[a], 4'h1);
    $display("test registers done");
    // rate codes, the last one with the master clock halved
    run <= 1'b1;
    wr(12'hB8B, 8'h02, 4'h1);
    for (k = 0; k < 4; k++)
    begin
      wr(12'hB8C, (k == 3) ? 8'h01 : 8'h00, 4'h1);
      wr(12'hB8A, {2'b00, codes[k][4:0], 1'b1}, 4'h1);
      get_out(t0);
      get_out(t0);
      get_out(t1);
      chk(t1 - t0, ratio[k], "output spacing");
      $display("test rate %0d done", ratio[k]);
    end
    wr(12'hB8C, 8'h00, 4'h1);
    // gain code zero with shift field zero scales by one over 256
    wr(12'hB12, 8'h00, 4'h1);
    get_out(t0);
    get_out(t0);
    chk(aud_data[15:7] == 9'h000 || aud_data[15:7] == 9'h1FF, 1'b1, "shift right eight");
    wr(12'hB12, `MLC_RST_MANUAL, 4'h1);
    // fill the fifo with the sink stalled, then drain it with the chain off
    wr(12'hB8A, 8'h1D, 4'h1);
    aud_ready <= 1'b0;
    repeat (40 * 125) @(posedge mclk);
    bus(1'b0, `MLC_IDX_STATUS, 8'h00, 4'h1);
    chk(rd[0], 1'b1, "overflow flag");
    wr(12'hB8B, 8'h00, 4'h1);
    aud_ready <= 1'b1;
    n = 0;
    for (k = 0; k < 300 && n < 100; k++)
    begin
      @(posedge mclk);
      if (aud_valid === 1'b1)
      begin
        n++;
        k = 0;
      end
    end
    chk(n >= 32 && n <= 36, 1'b1, "drained count");
    wr(`MLC_IDX_STATUS, 8'h01, 4'h1);
    bus(1'b0, `MLC_IDX_STATUS, 8'h00, 4'h1);
    chk(rd[0], 1'b0, "overflow clear");
    $display("test fifo done");
    // stereo level control: target 0 drives gain to floor 2, target 15 to ceiling 6
    sel_on = 1;
    wr(12'hBA4, 8'h02, 4'h1);
    wr(12'hBA2, 8'h00, 4'h1);
    wr(12'hBA0, 8'h60, 4'h1);
    wr(12'hBA1, 8'h60, 4'h1);
    wr(12'hB8B, 8'h02, 4'h1);
    repeat (30 * 125) @(posedge mclk);
    bus(1'b0, `MLC_IDX_STATUS, 8'h00, 4'h1);
    chk(rd[7:4], 4'h2, "gain at floor");
    wr(12'hBA0, 8'h6F, 4'h1);
    repeat (30 * 125) @(posedge mclk);
    bus(1'b0, `MLC_IDX_STATUS, 8'h00, 4'h1);
    chk(rd[7:4], 4'h6, "gain at ceiling");
    $display("test level control done");
    // noise gate with top threshold, every action; hard mute gives silence
    for (k = 0; k < 3; k++)
    begin
      wr(12'hBA3, {5'h1F, k[1:0], 1'b1}, 4'h1);
      repeat (10 * 125) @(posedge mclk);
      bus(1'b0, `MLC_IDX_STATUS, 8'h00, 4'h1);
      chk(rd[1], 1'b1, "gate active");
      get_out(t0);
      if (k == 1)
        chk(aud_data, 32'h00000000, "hard mute");
    end
    $display("test noise gate done");
    print_verdict();
  end
endmodule // mlc_top_tb
